// *** design/diag_rec_pkg.sv ***
/*
  constants for the analog i/o diagnostic record block: byte map, field
  positions, fixed codes, scaling figures and apb register offsets.
  assumes nothing of its surroundings.
*/
package diag_rec_pkg;
  // record bytes, byte index within record set 1 (set 0 is bytes 0..3)
  localparam int REC_BYTES = 12;
  localparam int REC0_BYTES = 4;
  localparam logic [3:0] B_FAULT = 4'h0;
  localparam logic [3:0] B_CLASS = 4'h1;
  localparam logic [3:0] B_RSV2 = 4'h2;
  localparam logic [3:0] B_RSV3 = 4'h3;
  localparam logic [3:0] B_TYPE = 4'h4;
  localparam logic [3:0] B_NBITS = 4'h5;
  localparam logic [3:0] B_NCHAN = 4'h6;
  localparam logic [3:0] B_CHERR = 4'h7;
  localparam logic [3:0] B_IN01 = 4'h8;
  localparam logic [3:0] B_IN23 = 4'h9;
  localparam logic [3:0] B_OUT45 = 4'hA;
  localparam logic [3:0] B_RSV11 = 4'hB;
  // byte 0 fields
  localparam int F_MALF = 0;
  localparam int F_EXTERR = 2;
  localparam int F_CHERR = 3;
  localparam int F_NOSUP = 4;
  localparam int F_BADPAR = 7;
  // byte 1 fields
  localparam logic [3:0] CLASS_ANALOG = 4'h5;
  localparam int F_CHINFO = 4;
  // fixed bytes
  localparam logic [7:0] FAULT_RESET = 8'h00;
  localparam logic [7:0] CLASS_RESET = 8'h15;
  localparam logic [6:0] TYPE_ANALOG_IO = 7'h74;
  localparam logic [7:0] NBITS_PER_CH = 8'h04;
  localparam logic [7:0] NUM_CHANNELS = 8'h06;
  localparam int N_IN = 4;
  localparam int N_OUT = 2;
  // output channel flag positions within byte 10
  localparam int F_OUT4 = 0;
  localparam int F_OUT5 = 4;
  // scaling
  localparam int FULL_SCALE = 27648;
  localparam int MA_LIVE_ZERO = 4;
  localparam int MA_LZ_SPAN = 16;
  localparam int V_LIVE_ZERO = 1;
  localparam int V_LZ_SPAN = 4;
  // apb map: record bytes 0..11 at word index*4, then control words
  localparam logic [7:0] A_REC_LAST = 8'h2C;
  localparam logic [7:0] A_CTRL = 8'h30;
  localparam logic [7:0] A_IRQ_STAT = 8'h34;
  localparam logic [7:0] A_IRQ_MASK = 8'h38;
  localparam logic [7:0] A_SCALE_CFG = 8'h3C;
  localparam logic [7:0] A_SCALE_IN = 8'h40;
  localparam logic [7:0] A_SCALE_OUT = 8'h44;
  localparam int CTRL_ALARM_EN = 0;
  // irq status bits
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_CLEAR = 1;
  // scaling range codes
  typedef enum logic [2:0] {
    RNG_BIPOLAR, RNG_UNIPOLAR, RNG_LIVE_ZERO_MA, RNG_LIVE_ZERO_V
  } range_e;
endpackage

// *** design/diag_rec.sv ***
/*
  diagnostic record bank with apb slave, alarm push and value scaler.
  assumes fault inputs come from logic on i_ref_clk, one apb master,
  and a downstream record sender that pulses i_send_ack.
*/
// Summary of operation
// - current scaled two's complement, full scale 27648, live zero minus 4 mA
// - voltage scaled, full scale 27648, 1-5 V range minus 1 V over 4 V
// - twelve diagnostic bytes held as record sets zero and one
// - alarm enabled: error detection sends record set zero to controller; code sends only on a new error edge with no push pending
// - record set zero is exactly four bytes
// - byte 0: bit0 malfunction, bit2 external, bit3 channel error, resets 00h
// - byte 0: bit4 supply missing, bit7 bad parameters, bits 5,6 zero
// - byte 1: class 0101 in bits 0-3, bits 5-7 reserved, default 15h
// - byte 1 bit 4 says channel information present
// - record set one repeats set zero then eight specific bytes
// - byte 4 holds type code 74h in bits 0-6
// - byte 5 holds 04h diagnostic bits per channel
// - byte 6 holds 06h identical channels
// - byte 7 channel error per channel 0-5, bits 6,7 zero
// - bytes 8,9 input nibbles: wire break, parameter, underflow, overflow
// - byte 10 outputs 4 and 5: break/short then parameter error
`timescale 1ns/1ps
module diag_rec
  import diag_rec_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_malfunction,
  input wire logic i_ext_error,
  input wire logic i_supply_missing,
  input wire logic i_bad_params,
  input wire logic [N_IN-1:0] i_in_wire_break,
  input wire logic [N_IN-1:0] i_in_param_err,
  input wire logic [N_IN-1:0] i_in_underflow,
  input wire logic [N_IN-1:0] i_in_overflow,
  input wire logic [N_OUT-1:0] i_out_break_short,
  input wire logic [N_OUT-1:0] i_out_param_err,
  input wire logic i_send_ack,
  output logic o_send_req,
  output logic [31:0] o_send_rec,
  output logic o_irq
);
  typedef struct packed {
    logic [7:0] fault;
    logic [7:0] cherr;
    logic [7:0] in01;
    logic [7:0] in23;
    logic [7:0] out45;
    logic err_seen;
    logic alarm_en;
    logic send_req;
    logic [31:0] send_rec;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [2:0] rng;
    logic [15:0] sc_in;
    logic [15:0] sc_out;
    logic [31:0] prdata;
  } state_s;

  state_s cur_ff;
  state_s nxt_ff;

  // scaling: value = raw_in (signed, sensor units * 1000) mapped by range
  function automatic logic [15:0] scale(input logic [2:0] rng, input logic [15:0] raw);
    logic signed [31:0] x;
    logic signed [31:0] r;
    x = 32'(signed'(raw));
    case (rng)
      3'(RNG_LIVE_ZERO_MA): r = ((x - MA_LIVE_ZERO * 1000) * FULL_SCALE) / (MA_LZ_SPAN * 1000);
      3'(RNG_LIVE_ZERO_V): r = ((x - V_LIVE_ZERO * 1000) * FULL_SCALE) / (V_LZ_SPAN * 1000);
      default: r = (x * FULL_SCALE) / 1000;
    endcase
    if (r > 32767) r = 32767;
    if (r < -32768) r = -32768;
    return r[15:0];
  endfunction

  function automatic logic [7:0] rec_byte(input state_s s, input logic [3:0] idx);
    case (idx)
      B_FAULT: rec_byte = s.fault;
      // set one always carries channel detail, so bit 4 stays high
      B_CLASS: rec_byte = {3'h0, 1'b1, CLASS_ANALOG};
      B_TYPE: rec_byte = {1'b0, TYPE_ANALOG_IO};
      B_NBITS: rec_byte = NBITS_PER_CH;
      B_NCHAN: rec_byte = NUM_CHANNELS;
      B_CHERR: rec_byte = s.cherr;
      B_IN01: rec_byte = s.in01;
      B_IN23: rec_byte = s.in23;
      B_OUT45: rec_byte = s.out45;
      default: rec_byte = 8'h00;
    endcase
  endfunction

  logic acc;
  logic [7:0] fault_c;
  logic [7:0] cherr_c;
  logic [7:0] in01_c;
  logic [7:0] in23_c;
  logic [7:0] out45_c;
  logic err_now;

  always_comb begin
    acc = i_psel && i_penable;
    // input nibbles, bit 0 up: break, parameter, underflow, overflow
    in01_c = {i_in_overflow[1], i_in_underflow[1], i_in_param_err[1], i_in_wire_break[1],
              i_in_overflow[0], i_in_underflow[0], i_in_param_err[0], i_in_wire_break[0]};
    in23_c = {i_in_overflow[3], i_in_underflow[3], i_in_param_err[3], i_in_wire_break[3],
              i_in_overflow[2], i_in_underflow[2], i_in_param_err[2], i_in_wire_break[2]};
    out45_c = 8'h00;
    out45_c[F_OUT4] = i_out_break_short[0];
    out45_c[F_OUT4+1] = i_out_param_err[0];
    out45_c[F_OUT5] = i_out_break_short[1];
    out45_c[F_OUT5+1] = i_out_param_err[1];
    cherr_c = {2'b00, |out45_c[5:4], |out45_c[1:0], |in23_c[7:4], |in23_c[3:0],
               |in01_c[7:4], |in01_c[3:0]};
    fault_c = FAULT_RESET;
    fault_c[F_MALF] = i_malfunction;
    fault_c[F_EXTERR] = i_ext_error;
    fault_c[F_CHERR] = |cherr_c;
    fault_c[F_NOSUP] = i_supply_missing;
    fault_c[F_BADPAR] = i_bad_params;
    err_now = |fault_c;

    nxt_ff = cur_ff;
    nxt_ff.fault = fault_c;
    nxt_ff.cherr = cherr_c;
    nxt_ff.in01 = in01_c;
    nxt_ff.in23 = in23_c;
    nxt_ff.out45 = out45_c;
    nxt_ff.err_seen = err_now;
    nxt_ff.sc_out = scale(cur_ff.rng, cur_ff.sc_in);

    // apb write/read and interrupt clear; set below wins over clear
    nxt_ff.prdata = 32'h0000_0000;
    if (acc && i_pwrite) begin
      case (i_paddr)
        A_CTRL: nxt_ff.alarm_en = i_pwdata[CTRL_ALARM_EN];
        A_IRQ_STAT: nxt_ff.irq_stat = cur_ff.irq_stat & ~i_pwdata[1:0];
        A_IRQ_MASK: nxt_ff.irq_mask = i_pwdata[1:0];
        A_SCALE_CFG: nxt_ff.rng = i_pwdata[2:0];
        A_SCALE_IN: nxt_ff.sc_in = i_pwdata[15:0];
        default: ;
      endcase
    end
    if (i_psel && !i_penable && !i_pwrite) begin
      if (i_paddr <= A_REC_LAST && i_paddr[1:0] == 2'b00) begin
        nxt_ff.prdata = {24'h0, rec_byte(cur_ff, i_paddr[5:2])};
      end else begin
        case (i_paddr)
          A_CTRL: nxt_ff.prdata = {31'h0, cur_ff.alarm_en};
          A_IRQ_STAT: nxt_ff.prdata = {30'h0, cur_ff.irq_stat};
          A_IRQ_MASK: nxt_ff.prdata = {30'h0, cur_ff.irq_mask};
          A_SCALE_CFG: nxt_ff.prdata = {29'h0, cur_ff.rng};
          A_SCALE_IN: nxt_ff.prdata = {16'h0, cur_ff.sc_in};
          A_SCALE_OUT: nxt_ff.prdata = {16'h0, cur_ff.sc_out};
          default: nxt_ff.prdata = 32'h0000_0000;
        endcase
      end
    end

    // a new error edge snapshots set zero; a pending push is not overrun
    if (cur_ff.send_req && i_send_ack) begin
      nxt_ff.send_req = 1'b0;
    end
    if (cur_ff.alarm_en && err_now && !cur_ff.err_seen && !cur_ff.send_req) begin
      nxt_ff.send_req = 1'b1;
      nxt_ff.send_rec = {16'h0000, rec_byte(cur_ff, B_CLASS), fault_c};
      nxt_ff.irq_stat[IRQ_ALARM] = 1'b1;
    end
    if (!err_now && cur_ff.err_seen) begin
      nxt_ff.irq_stat[IRQ_CLEAR] = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur_ff <= '0;
      cur_ff.rng <= 3'(RNG_BIPOLAR);
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // read data prepared in setup, so one wait-free access phase
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  assign o_prdata = cur_ff.prdata;
  assign o_send_req = cur_ff.send_req;
  assign o_send_rec = cur_ff.send_rec;
  assign o_irq = |(cur_ff.irq_stat & cur_ff.irq_mask);

  // byte-zero fields follow the fault inputs one cycle late
  fault_map_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    1'b1 |=> cur_ff.fault[F_MALF] == $past(i_malfunction)
      && cur_ff.fault[F_EXTERR] == $past(i_ext_error)
      && cur_ff.fault[1] == 1'b0)
    else $error("byte zero field mismatch");

  fault_rsv_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    1'b1 |=> cur_ff.fault[6:5] == 2'b00
      && cur_ff.fault[F_BADPAR] == $past(i_bad_params))
    else $error("byte zero upper bits wrong");

  supply_bit_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(i_supply_missing) |=> cur_ff.fault[F_NOSUP])
    else $error("supply missing not flagged");

  // channel summary and per-channel or terms
  cherr_or_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    cur_ff.fault[F_CHERR] == |cur_ff.cherr[5:0])
    else $error("channel error summary wrong");

  chan_rsv_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    cur_ff.cherr[7:6] == 2'b00)
    else $error("channel error reserved bits set");

  ch0_or_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_in_wire_break[0] || i_in_overflow[0]) |=> cur_ff.cherr[0])
    else $error("channel 0 error not set");

  ch4_or_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_out_break_short[0] |=> cur_ff.out45[F_OUT4] && cur_ff.cherr[4])
    else $error("output 4 break flag lost");

  // nibble and output byte placement
  out_map_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_out_param_err[1] |=> cur_ff.out45[F_OUT5+1] && cur_ff.cherr[5])
    else $error("output 5 parameter flag lost");

  out_rsv_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    cur_ff.out45[3:2] == 2'b00 && cur_ff.out45[7:6] == 2'b00)
    else $error("output byte reserved bits set");

  in_nibble_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_in_overflow[3] |=> cur_ff.in23[7])
    else $error("input 3 overflow misplaced");

  in0_nibble_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_in_param_err[0] && i_in_underflow[2] |=> cur_ff.in01[1] && cur_ff.in23[2])
    else $error("input nibble flag misplaced");

  // fixed and reserved bytes never move
  fixed_bytes_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    rec_byte(cur_ff, B_TYPE) == 8'h74)
    else $error("channel type byte wrong");

  count_bytes_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    rec_byte(cur_ff, B_NBITS) == 8'h04 && rec_byte(cur_ff, B_NCHAN) == 8'h06)
    else $error("count byte wrong");

  rsv_bytes_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    rec_byte(cur_ff, B_RSV2) == 8'h00 && rec_byte(cur_ff, B_RSV3) == 8'h00
      && rec_byte(cur_ff, B_RSV11) == 8'h00)
    else $error("reserved record byte not zero");

  class_byte_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    rec_byte(cur_ff, B_CLASS) == 8'h15)
    else $error("class byte wrong");

  // reads: data launched by the setup edge stands in the access phase
  type_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_psel && !i_penable && !i_pwrite && i_paddr == 8'h10
      |=> o_prdata == 32'h0000_0074)
    else $error("type byte read wrong");

  count_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_psel && !i_penable && !i_pwrite && i_paddr == 8'h18
      |=> o_prdata == 32'h0000_0006)
    else $error("channel count read wrong");

  unmapped_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_psel && !i_penable && !i_pwrite && i_paddr == 8'h48
      |=> o_prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  prdata_idle_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    !i_psel |=> o_prdata == 32'h0000_0000)
    else $error("read data left on idle bus");

  // alarm push: one outstanding record, held until taken
  alarm_push_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    cur_ff.alarm_en && !cur_ff.send_req && $rose(|fault_c) ##0 !cur_ff.err_seen
      |=> o_send_req && o_send_rec[7:0] == $past(fault_c))
    else $error("alarm record not pushed");

  no_alarm_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    !cur_ff.alarm_en && !cur_ff.send_req |=> !o_send_req)
    else $error("record pushed while alarm disabled");

  send_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    o_send_req && !i_send_ack |=> o_send_req && $stable(o_send_rec))
    else $error("pending record not held");

  send_drop_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    o_send_req && i_send_ack |=> !o_send_req)
    else $error("request kept after acknowledge");

  rec_len_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    o_send_req |-> o_send_rec[31:16] == 16'h0000)
    else $error("record set zero longer than four bytes");

  chinfo_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    o_send_req |-> o_send_rec[8+F_CHINFO])
    else $error("channel information bit missing");

  rec_copy_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(o_send_req) |-> o_send_rec[7:0] == cur_ff.fault)
    else $error("pushed record differs from record bytes");

  irq_set_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(o_send_req) |-> cur_ff.irq_stat[IRQ_ALARM])
    else $error("alarm status not set");

  // scaler spot values; inputs must settle one cycle first
  scale_fs_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    cur_ff.rng == 3'(RNG_LIVE_ZERO_MA) && cur_ff.sc_in == 16'h4E20 ##1 $stable(cur_ff.sc_in)
      && $stable(cur_ff.rng) |=> cur_ff.sc_out == 16'h6C00)
    else $error("live zero full scale wrong");

  scale_v_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    cur_ff.rng == 3'(RNG_LIVE_ZERO_V) && cur_ff.sc_in == 16'h03E8 ##1 $stable(cur_ff.sc_in)
      && $stable(cur_ff.rng) |=> cur_ff.sc_out == 16'h0000)
    else $error("one volt offset wrong");

  // main scenarios
  alarm_seen_c: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_send_req ##[1:20] i_send_ack);

  slow_ack_c: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (o_send_req && !i_send_ack) [*7] ##1 i_send_ack);

  irq_seen_c: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) $rose(o_irq));

  rec_read_c: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    acc && !i_pwrite && i_paddr == 8'h1C && o_prdata != 32'h0);

  scale_v_c: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    cur_ff.rng == 3'(RNG_LIVE_ZERO_V) && cur_ff.sc_out == 16'h6C00);
endmodule // diag_rec

// *** bench/sender_model.sv ***
/*
  model of the downstream record sender that takes record set zero.
  assumes one clock with the design and the design's request level.
*/
`timescale 1ns/1ps
module sender_model (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_send_req,
  input wire logic i_slow,
  output logic o_send_ack
);
  logic [3:0] wait_ff;
  // one ack pulse per request, short or long wait; idle otherwise
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wait_ff <= 4'h0;
      o_send_ack <= 1'b0;
    end else if (i_send_req && !o_send_ack) begin
      wait_ff <= wait_ff + 4'h1;
      o_send_ack <= (wait_ff >= (i_slow ? 4'h6 : 4'h0));
    end else begin
      wait_ff <= 4'h0;
      o_send_ack <= 1'b0;
    end
  end
endmodule // sender_model

// *** bench/tb_analog_io_diagnostic_records.sv ***
/*
  self-checking bench for diag_rec: apb reads, faults, alarm, scaling.
  assumes pready may stall; results are queued and checked by a watcher.
*/
`timescale 1ns/1ps
module tb_analog_io_diagnostic_records;
  import diag_rec_pkg::*;
  logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic i_pwrite = 1'b0, slow = 1'b0, rd_got = 1'b0, o_pready, o_pslverr, o_send_req, o_irq;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, o_send_rec, rd_data;
  logic i_malfunction = 0, i_ext_error = 0, i_supply_missing = 0, i_bad_params = 0;
  logic [3:0] i_in_wire_break = 0, i_in_param_err = 0, i_in_underflow = 0, i_in_overflow = 0;
  logic [1:0] i_out_break_short = 0, i_out_param_err = 0;
  logic i_send_ack;
  logic [31:0] exp_q[$], msk_q[$], snd_q[$];
  logic [7:0] rv[12] = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h74, 8'h04, 8'h06, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  int bad_count = 0, checks = 0;
  always #2 i_ref_clk = ~i_ref_clk;
  diag_rec uut (.i_ref_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_malfunction, .i_ext_error, .i_supply_missing,
    .i_bad_params, .i_in_wire_break, .i_in_param_err, .i_in_underflow, .i_in_overflow,
    .i_out_break_short, .i_out_param_err, .i_send_ack, .o_send_req, .o_send_rec, .o_irq);
  sender_model far (.i_ref_clk, .i_reset_n, .i_send_req(o_send_req), .i_slow(slow),
    .o_send_ack(i_send_ack));
  task automatic finish_test;
    // a note left in a queue is a result that never appeared
    if (exp_q.size() != 0 || snd_q.size() != 0) bad_count++;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    checks++;
    if (((got ^ exp) & m) !== 32'h0) begin
      bad_count++;
      $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t irq got %b exp %b", $time, got, exp);
    end
  endtask
  // watcher: any result that appears takes the oldest note
  always @(posedge i_ref_clk) begin
    if (rd_got) cmp_word(rd_data, exp_q.pop_front(), msk_q.pop_front());
    if (o_send_req && i_send_ack) cmp_word(o_send_rec, snd_q.pop_front(), 32'hFFFF_FFFF);
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk) i_penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      finish_test;
    end
    rd_data <= o_prdata;
    rd_got <= !w;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_ref_clk) rd_got <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_req(input logic lvl);
    int n;
    for (n = 0; n < 30 && o_send_req !== lvl; n++) @(posedge i_ref_clk);
    if (n >= 30) begin
      bad_count++;
      finish_test;
    end
  endtask
  logic [23:0] v;
  logic [5:0] ch;
  int code[6] = '{2, 2, 2, 3, 3, 3};
  int vin[6] = '{4000, 12000, 20000, 1000, 3000, 5000};
  int ex;
  initial begin
    void'($urandom(96345));
    repeat (6) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    apb(1'b1, 8'h00, 32'hFF);
    for (int i = 0; i < 12; i++) rd(8'(i * 4), rv[i], 32'hFF);
    rd(8'h48, 32'h0, 32'hFFFF_FFFF);
    $display("test reset values done");
    repeat (20) begin
      v = 24'($urandom);
      {i_bad_params, i_supply_missing, i_ext_error, i_malfunction, i_out_param_err,
        i_out_break_short, i_in_overflow, i_in_underflow, i_in_param_err, i_in_wire_break} <= v;
      for (int c = 0; c < 4; c++) ch[c] = v[c] | v[4 + c] | v[8 + c] | v[12 + c];
      ch[4] = v[16] | v[18];
      ch[5] = v[17] | v[19];
      repeat (2) @(posedge i_ref_clk);
      rd(8'h00, {v[23], 2'b0, v[22], |ch, v[21], 1'b0, v[20]}, 32'hFF);
      rd(8'h04, 32'h15, 32'hFF);
      rd(8'h1C, {2'b0, ch}, 32'hFF);
      rd(8'h20, {v[13], v[9], v[5], v[1], v[12], v[8], v[4], v[0]}, 32'hFF);
      rd(8'h24, {v[15], v[11], v[7], v[3], v[14], v[10], v[6], v[2]}, 32'hFF);
      rd(8'h28, {2'b0, v[19], v[17], 2'b0, v[18], v[16]}, 32'hFF);
      rd(8'h2C, 32'h0, 32'hFF);
    end
    $display("test fault records done");
    {i_bad_params, i_supply_missing, i_ext_error, i_malfunction, i_out_param_err,
      i_out_break_short, i_in_overflow, i_in_underflow, i_in_param_err, i_in_wire_break} <= 0;
    repeat (3) @(posedge i_ref_clk);
    apb(1'b1, A_IRQ_STAT, 32'h3);
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b1, A_IRQ_MASK, 32'h1);
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      snd_q.push_back(32'h0000_1504);
      i_ext_error <= 1'b1;
      @(posedge i_ref_clk);
      wait_req(1'b1);
      wait_req(1'b0);
      cmp_bit(o_irq, 1'b1);
      apb(1'b1, A_IRQ_STAT, 32'h1);
      cmp_bit(o_irq, 1'b0);
      i_ext_error <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
    end
    $display("test alarm push done");
    for (int k = 0; k < 6; k++) begin
      if (code[k] == 2) ex = (vin[k] - MA_LIVE_ZERO * 1000) * FULL_SCALE / (MA_LZ_SPAN * 1000);
      else ex = (vin[k] - V_LIVE_ZERO * 1000) * FULL_SCALE / (V_LZ_SPAN * 1000);
      apb(1'b1, A_SCALE_CFG, 32'(code[k]));
      apb(1'b1, A_SCALE_IN, 32'(vin[k]));
      repeat (3) @(posedge i_ref_clk);
      rd(A_SCALE_OUT, 32'(ex), 32'hFFFF);
    end
    $display("test scaling done");
    repeat (3) @(posedge i_ref_clk);
    finish_test;
  end
endmodule // tb_analog_io_diagnostic_records
